/* ftc_consts.vh */
// Constants for the flow totalizer core
`ifndef FTC_CONSTS_VH
`define FTC_CONSTS_VH

// Register offsets (word index on the register port)
`define FTC_A_CTRL      4'h0
`define FTC_A_KFACTOR   4'h1
`define FTC_A_HI_LIM    4'h2
`define FTC_A_LO_LIM    4'h3
`define FTC_A_PRESET    4'h4
`define FTC_A_PRE_WARN  4'h5
`define FTC_A_SCALER    4'h6
`define FTC_A_RELAY_CFG 4'h7
`define FTC_A_SERIAL    4'h8
`define FTC_A_AVG       4'h9
`define FTC_A_UNLOCK    4'hA
`define FTC_A_TOTAL     4'hB
`define FTC_A_RATE      4'hC
`define FTC_A_STATUS    4'hD
`define FTC_A_ANALOG    4'hE
`define FTC_A_AUDIT     4'hF

// Control register fields
`define FTC_CTRL_PW100  0
`define FTC_CTRL_AOTOT  1
`define FTC_CTRL_RLY4   2
`define FTC_CTRL_RUN    3
`define FTC_CTRL_RESET  32'h0000_0008

// Default values
`define FTC_KFACTOR_RST 32'h0000_0001
`define FTC_SCALER_RST  32'h0000_0001
`define FTC_RELAY_RST   32'h0000_0021
`define FTC_SERIAL_RST  32'h0001_1401
`define FTC_AVG_RST     32'h0000_0002
`define FTC_LOCK_RST    32'h0000_04D2
`define FTC_MFG_CODE    32'h0000_5A5A

// Relay functions
`define FTC_RF_UNUSED   3'h0
`define FTC_RF_LORATE   3'h1
`define FTC_RF_HIRATE   3'h2
`define FTC_RF_PREWARN  3'h3
`define FTC_RF_PRESET   3'h4
`define FTC_RF_SECURITY 3'h5
`define FTC_RF_OVERRUN  3'h6

// Serial field limits
`define FTC_ID232_MAX   8'h63
`define FTC_ID485_MAX   8'hF7

// Timing
`define FTC_CLK_HZ      100000000
`define FTC_PULSE_SHORT_MS 10
`define FTC_PULSE_LONG_MS  100
`define FTC_PULSE_SHORT_CYC ((`FTC_CLK_HZ / 1000) * `FTC_PULSE_SHORT_MS)
`define FTC_PULSE_LONG_CYC  ((`FTC_CLK_HZ / 1000) * `FTC_PULSE_LONG_MS)
`define FTC_CYCLE_MS    100
`define FTC_CYCLE_CYC   ((`FTC_CLK_HZ / 1000) * `FTC_CYCLE_MS)

`endif

/* ftc_core.v */
// Flow totalizer core: measurement cycle, alarms, totals, pulse and analog out
`include "ftc_consts.vh"

module ftc_core #(
	parameter CYCLE_CYC = `FTC_CYCLE_CYC,
	parameter SHORT_CYC = `FTC_PULSE_SHORT_CYC,
	parameter LONG_CYC  = `FTC_PULSE_LONG_CYC
) (
	// Clock and reset
	input  wire        i_clk_sys,
	input  wire        i_rst,
	// Flowmeter pulse, synchronous
	input  wire        i_flow_pulse,
	// Register port
	input  wire [3:0]  i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [31:0] o_rdata,
	// Outputs
	output reg  [3:0]  o_relay,
	output reg         o_pulse_out,
	output reg  [11:0] o_analog,
	output reg  [31:0] o_serial_cfg,
	output reg         o_setup_mode,
	output reg         o_maint_mode
);

	localparam [3:0] ST_MEAS = 4'h0, ST_FLOW = 4'h1, ST_ALARM = 4'h2, ST_TOTAL = 4'h3,
		ST_PRESET = 4'h4, ST_PULSE = 4'h5, ST_ANALOG = 4'h6, ST_TABLE = 4'h7,
		ST_WAIT = 4'h8;

	// Decode one relay's function against current alarm levels
	function rly_fn;
		input [2:0] fn;
		input [5:0] ev;
		begin
			case (fn)
				`FTC_RF_LORATE:   rly_fn = ev[0];
				`FTC_RF_HIRATE:   rly_fn = ev[1];
				`FTC_RF_PREWARN:  rly_fn = ev[2];
				`FTC_RF_PRESET:   rly_fn = ev[3];
				`FTC_RF_SECURITY: rly_fn = ev[4];
				`FTC_RF_OVERRUN:  rly_fn = ev[5];
				default:          rly_fn = 1'b0;
			endcase
		end
	endfunction

	// Serial config validity check
	function ser_ok;
		input [31:0] v;
		reg   [2:0]  baud;
		begin
			baud = v[10:8];
			if (v[16]) begin
				ser_ok = (v[7:0] >= 8'h01) && (v[7:0] <= `FTC_ID485_MAX) && (baud >= 3'h3)
					&& (baud <= 3'h6) && (v[13:12] != 2'h3);
			end else begin
				ser_ok = (v[7:0] >= 8'h01) && (v[7:0] <= `FTC_ID232_MAX) && (baud <= 3'h6)
					&& (v[13:12] != 2'h3) && (v[15:14] != 2'h3);
			end
		end
	endfunction

	reg [31:0] ctrl_reg, kfac_reg, hi_reg, lo_reg, pre_reg, warn_reg, scal_reg;
	reg [31:0] rcfg_reg, avg_reg, lock_reg;
	reg [31:0] total_reg, rate_reg, frac_reg, resid_reg, audit_reg;
	reg [15:0] cnt_reg, snap_reg;
	reg [3:0]  st_reg;
	reg [26:0] tmr_reg, ptmr_reg;
	reg [7:0]  pbuf_reg;
	reg [5:0]  ev_reg;
	reg [23:0] avg_acc_reg;
	reg [31:0] inc_reg;
	reg        prev_pulse_reg, overrun_reg, security_reg;
	reg [31:0] div_q;
	reg [31:0] div_r;
	reg [31:0] tot_next;
	reg [11:0] sample;
	integer    k;
	wire       locked = ~o_setup_mode;
	wire       rising = i_flow_pulse & ~prev_pulse_reg;
	wire       two_rly = ~ctrl_reg[`FTC_CTRL_RLY4];

	////////////////////////////////////////////////////////////////////////////
	// Remainder division by the K-factor and analog source select
	always @* begin
		div_q = 32'h0;
		div_r = 32'h0;
		for (k = 31; k >= 0; k = k - 1) begin
			div_r = {div_r[30:0], frac_reg[k] };
			if (div_r >= kfac_reg && kfac_reg != 32'h0) begin
				div_r    = div_r - kfac_reg;
				div_q[k] = 1'b1;
			end
		end
		tot_next = total_reg + div_q;
		sample   = ctrl_reg[`FTC_CTRL_AOTOT] ? total_reg[11:0] : rate_reg[11:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes, lockout and audit
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			ctrl_reg     <= `FTC_CTRL_RESET;
			kfac_reg     <= `FTC_KFACTOR_RST;
			hi_reg       <= 32'hFFFF_FFFF;
			lo_reg       <= 32'h0;
			pre_reg      <= 32'hFFFF_FFFF;
			warn_reg     <= 32'hFFFF_FFFF;
			scal_reg     <= `FTC_SCALER_RST;
			rcfg_reg     <= `FTC_RELAY_RST;
			avg_reg      <= `FTC_AVG_RST;
			lock_reg     <= `FTC_LOCK_RST;
			o_serial_cfg <= `FTC_SERIAL_RST;
			o_setup_mode <= 1'b0;
			o_maint_mode <= 1'b0;
			audit_reg    <= 32'h0;
			security_reg <= 1'b0;
		end else if (i_wr) begin
			if (i_addr == `FTC_A_UNLOCK) begin
				// user code or manufacturer code opens setup
				if (i_wdata == lock_reg || i_wdata == `FTC_MFG_CODE) begin
					o_setup_mode <= 1'b1;
					o_maint_mode <= 1'b1;
				end else if (i_wdata == 32'h0) begin
					o_setup_mode <= 1'b0;
					o_maint_mode <= 1'b0;
				end else begin
					security_reg <= 1'b1;
				end
			end else if (locked) begin
				security_reg <= 1'b1;
			end else begin
				audit_reg <= audit_reg + 32'h1;
				case (i_addr)
					`FTC_A_CTRL:      ctrl_reg <= i_wdata;
					`FTC_A_KFACTOR:   kfac_reg <= i_wdata;
					`FTC_A_HI_LIM:    hi_reg   <= i_wdata;
					`FTC_A_LO_LIM:    lo_reg   <= i_wdata;
					`FTC_A_PRESET:    pre_reg  <= i_wdata;
					`FTC_A_PRE_WARN:  warn_reg <= i_wdata;
					`FTC_A_SCALER:    scal_reg <= i_wdata;
					`FTC_A_RELAY_CFG: rcfg_reg <= i_wdata;
					`FTC_A_SERIAL:    if (ser_ok(i_wdata)) o_serial_cfg <= i_wdata;
					`FTC_A_AVG:       avg_reg  <= i_wdata;
					`FTC_A_STATUS:    security_reg <= 1'b0;
					`FTC_A_AUDIT:     lock_reg <= i_wdata;
					default: begin
						// Read-only words take no value
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_rdata <= 32'h0;
		end else if (i_rd) begin
			case (i_addr)
				`FTC_A_CTRL:      o_rdata <= ctrl_reg;
				`FTC_A_KFACTOR:   o_rdata <= kfac_reg;
				`FTC_A_HI_LIM:    o_rdata <= hi_reg;
				`FTC_A_LO_LIM:    o_rdata <= lo_reg;
				`FTC_A_PRESET:    o_rdata <= (rcfg_reg[11:0] == 12'h0) ? 32'h0 : pre_reg;
				`FTC_A_PRE_WARN:  o_rdata <= warn_reg;
				`FTC_A_SCALER:    o_rdata <= scal_reg;
				`FTC_A_RELAY_CFG: o_rdata <= two_rly ? {20'h0, 6'h0, rcfg_reg[5:0]} : rcfg_reg;
				`FTC_A_SERIAL:    o_rdata <= o_serial_cfg;
				`FTC_A_AVG:       o_rdata <= avg_reg;
				`FTC_A_TOTAL:     o_rdata <= total_reg;
				`FTC_A_RATE:      o_rdata <= rate_reg;
				`FTC_A_STATUS:    o_rdata <= {16'h0, pbuf_reg, 2'h0, ev_reg};
				`FTC_A_ANALOG:    o_rdata <= {20'h0, o_analog};
				`FTC_A_AUDIT:     o_rdata <= audit_reg;
				default:          o_rdata <= 32'h0;
			endcase
		end else begin
			o_rdata <= 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Measurement cycle
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			st_reg <= ST_WAIT;
			tmr_reg <= 27'h0;
			cnt_reg <= 16'h0;
			snap_reg <= 16'h0;
			prev_pulse_reg <= 1'b0;
			rate_reg <= 32'h0;
			frac_reg <= 32'h0;
			total_reg <= 32'h0;
			ev_reg <= 6'h0;
			overrun_reg <= 1'b0;
			inc_reg <= 32'h0;
			resid_reg <= 32'h0;
			avg_acc_reg <= 24'h0;
			o_analog <= 12'h0;
			o_relay <= 4'h0;
		end else begin
			prev_pulse_reg <= i_flow_pulse;
			tmr_reg <= (tmr_reg == CYCLE_CYC[26:0] - 27'h1) ? 27'h0 : tmr_reg + 27'h1;
			// An edge in the snapshot cycle goes into the snapshot only, never twice
			if (st_reg == ST_MEAS) begin
				cnt_reg <= 16'h0;
			end else if (rising) begin
				cnt_reg <= cnt_reg + 16'h1;
			end
			case (st_reg)
				ST_MEAS: begin
					snap_reg <= cnt_reg + {15'h0, rising};
					st_reg <= ST_FLOW;
				end
				ST_FLOW: begin
					rate_reg <= {16'h0, snap_reg};
					frac_reg <= div_r + {16'h0, snap_reg};
					st_reg <= ST_ALARM;
				end
				ST_ALARM: begin
					ev_reg[0] <= rate_reg < lo_reg;
					ev_reg[1] <= rate_reg > hi_reg;
					st_reg <= ST_TOTAL;
				end
				ST_TOTAL: begin
					// natural wrap of the 32 bit total
					total_reg <= tot_next;
					overrun_reg <= tot_next < total_reg;
					inc_reg <= div_q;
					frac_reg <= div_r;
					st_reg <= ST_PRESET;
				end
				ST_PRESET: begin
					ev_reg[2] <= total_reg >= warn_reg;
					ev_reg[3] <= total_reg >= pre_reg;
					ev_reg[4] <= security_reg;
					ev_reg[5] <= overrun_reg;
					st_reg <= ST_PULSE;
				end
				ST_PULSE: begin
					resid_reg <= resid_reg + inc_reg * scal_reg;
					st_reg <= ST_ANALOG;
				end
				ST_ANALOG: begin
					// exponential average, shift by user constant
					avg_acc_reg <= avg_acc_reg - (avg_acc_reg >> avg_reg[3:0])
						+ ({12'h0, sample} << (4'hC - avg_reg[3:0]));
					st_reg <= ST_TABLE;
				end
				ST_TABLE: begin
					// twelve bit value, updated every cycle
					o_analog <= avg_acc_reg[23:12];
					st_reg <= ST_WAIT;
				end
				ST_WAIT: begin
					if (tmr_reg == 27'h0) st_reg <= ST_MEAS;
				end
				default: st_reg <= ST_WAIT;
			endcase
			o_relay[0] <= rly_fn(rcfg_reg[2:0], ev_reg);
			o_relay[1] <= rly_fn(rcfg_reg[5:3], ev_reg);
			o_relay[2] <= ~two_rly & rly_fn(rcfg_reg[8:6], ev_reg);
			o_relay[3] <= ~two_rly & rly_fn(rcfg_reg[11:9], ev_reg);
			if (st_reg != ST_PULSE && resid_reg != 32'h0 && pbuf_reg != 8'hFF)
				resid_reg <= resid_reg - 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pulse buffer and output timer
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			pbuf_reg <= 8'h0;
			ptmr_reg <= 27'h0;
			o_pulse_out <= 1'b0;
		end else begin
			// full buffer leaves value in residual
			if (st_reg != ST_PULSE && resid_reg != 32'h0 && pbuf_reg != 8'hFF) begin
				if (!(ptmr_reg == 27'h0 && !o_pulse_out && pbuf_reg != 8'h0))
					pbuf_reg <= pbuf_reg + 8'h1;
			end else if (ptmr_reg == 27'h0 && !o_pulse_out && pbuf_reg != 8'h0) begin
				pbuf_reg <= pbuf_reg - 8'h1;
			end
			// 10 or 100 ms high then one clock low
			// One low clock between pulses keeps the far counter's edges apart
			if (ptmr_reg != 27'h0) begin
				ptmr_reg <= ptmr_reg - 27'h1;
				if (ptmr_reg == 27'h1) o_pulse_out <= 1'b0;
			end else if (o_pulse_out) begin
				o_pulse_out <= 1'b0;
			end else if (pbuf_reg != 8'h0) begin
				o_pulse_out <= 1'b1;
				ptmr_reg <= ctrl_reg[`FTC_CTRL_PW100] ? LONG_CYC[26:0] : SHORT_CYC[26:0];
			end
		end
	end

endmodule

/* ftc_flow_partner.sv */
// Flowmeter pulse source and remote pulse counter model
module ftc_flow_partner (
	// Clock
	input  wire logic i_clk_sys,
	// Counter side
	input  wire logic i_count_pulse,
	// Flowmeter side
	output wire logic o_flow_pulse,
	// Counter results
	output wire logic [31:0] o_count,
	output wire logic [31:0] o_width
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flow = 1'h0;
	int   run = 0;
	int   cnt = 0;
	int   wid = 0;
	assign o_flow_pulse = flow;
	assign o_count = cnt;
	assign o_width = wid;
	// Each meter pulse is high one clock, low two
	task automatic send(input int n);
		repeat (n) begin
			@(posedge i_clk_sys) flow <= 1'h1;
			@(posedge i_clk_sys) flow <= 1'h0;
			@(posedge i_clk_sys);
		end
	endtask
	// Counter keeps the high time of the last pulse
	always @(posedge i_clk_sys) begin
		if (i_count_pulse) begin
			run <= run + 1;
		end else if (run != 0) begin
			cnt <= cnt + 1;
			wid <= run;
			run <= 0;
		end
	end
endmodule

/* ftc_core_checker.sv */
// Port checker for the flow totalizer core
module ftc_core_checker #(
	parameter SHORT_CYC = 5,
	parameter LONG_CYC  = 20
) (
	// Watched ports
	input wire        i_clk_sys,
	input wire        i_rst,
	input wire [3:0]  i_addr,
	input wire [31:0] i_wdata,
	input wire        i_wr,
	input wire        i_rd,
	input wire [31:0] o_rdata,
	input wire [3:0]  o_relay,
	input wire        o_pulse_out,
	input wire [31:0] o_serial_cfg,
	input wire        o_setup_mode
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	logic rly4;
	logic pw100;
	int   hi_len;
	wire  unl_w = i_wr && i_addr == 4'hA;
	wire  ser_w = i_wr && i_addr == 4'h8;
	// Shadow of control bits written while open
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rly4 <= 1'h0;
			pw100 <= 1'h0;
			hi_len <= 0;
		end else begin
			if (i_wr && i_addr == 4'h0 && o_setup_mode) begin
				rly4 <= i_wdata[2];
				pw100 <= i_wdata[0];
			end
			hi_len <= o_pulse_out ? hi_len + 1 : 0;
		end
	end
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside answer cycle");
	pulse_width_a: assert property (
		$fell(o_pulse_out) |-> hi_len == (pw100 ? LONG_CYC : SHORT_CYC))
		else $error("output pulse width wrong");
	pulse_min_a: assert property ($rose(o_pulse_out) |=> o_pulse_out [*4])
		else $error("output pulse too short");
	cfg_reset_a: assert property (
		$fell(i_rst) |-> o_serial_cfg == 32'h0001_1401 && o_relay == 4'h0 && !o_setup_mode)
		else $error("outputs not at defaults after reset");
	relay_two_a: assert property (!rly4 && !$past(rly4, 2) |-> o_relay[3:2] == 2'h0)
		else $error("optional relays driven");
	unlock_open_a: assert property (
		unl_w && (i_wdata == 32'h4D2 || i_wdata == 32'h5A5A) |-> ##[1:2] o_setup_mode)
		else $error("unlock code did not open setup");
	lock_close_a: assert property (unl_w && i_wdata == 32'h0 |-> ##[1:2] !o_setup_mode)
		else $error("setup not closed");
	setup_cause_a: assert property (
		$rose(o_setup_mode) |-> $past(unl_w) || $past(unl_w, 2))
		else $error("setup opened without unlock write");
	serial_keep_a: assert property (
		$changed(o_serial_cfg) |-> $past(ser_w) || $past(ser_w, 2))
		else $error("serial config changed without write");
	cover property ($fell(o_pulse_out) && pw100);
	cover property ($rose(o_setup_mode));
	cover property ($rose(o_relay[2]));
endmodule
bind ftc_core ftc_core_checker #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) ftc_core_checker_i (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_relay(o_relay),
	.o_pulse_out(o_pulse_out), .o_serial_cfg(o_serial_cfg), .o_setup_mode(o_setup_mode)
);

/* ftc_core_bench.sv */
// Self-checking bench for the flow totalizer core
module ftc_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        fl;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'h0;
	logic        rd = 1'h0;
	logic [31:0] rdata;
	logic [3:0]  relay;
	logic        pout;
	logic [31:0] scfg;
	logic        setup;
	logic        maint;
	logic [11:0] ana;
	logic [31:0] rv;
	int          cnt;
	int          wid;
	int          n_mismatch = 0;
	int          comparisons = 0;
	logic [3:0]  ra [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9};
	logic [31:0] dv [9] = '{32'h8, 32'h1, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF,
		32'hFFFFFFFF, 32'h1, 32'h21, 32'h2};
	always #5 clk = ~clk;
	ftc_core #(.CYCLE_CYC(200), .SHORT_CYC(5), .LONG_CYC(20)) ftc_core_i (
		.i_clk_sys(clk), .i_rst(rst), .i_flow_pulse(fl), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_relay(relay), .o_pulse_out(pout),
		.o_analog(ana), .o_serial_cfg(scfg), .o_setup_mode(setup), .o_maint_mode(maint)
	);
	ftc_flow_partner ftc_flow_partner_i (
		.i_clk_sys(clk), .i_count_pulse(pout), .o_flow_pulse(fl), .o_count(cnt), .o_width(wid)
	);
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wrr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		rv = rdata;
	endtask
	task automatic flow(input int n, input int t, input int c, input int w);
		ftc_flow_partner_i.send(n);
		idle(2600);
		rdr(4'hB);
		chk("total", rv, t);
		chk("pulse count", cnt, c);
		chk("pulse width", wid, w);
	endtask
	task automatic finish_test;
		$display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 9; i++) begin
			rdr(ra[i]);
			chk("default", rv, dv[i]);
		end
		chk("serial default", scfg, 32'h0001_1401);
		wrr(4'h1, 32'h3);
		idle(220);
		rdr(4'h1);
		chk("locked kfactor", rv, 32'h1);
		rdr(4'hD);
		chk("security flag", {31'h0, rv[4]}, 32'h1);
		wrr(4'hA, 32'h4D2);
		idle(2);
		chk("setup open", {31'h0, setup}, 32'h1);
		chk("maint open", {31'h0, maint}, 32'h1);
		wrr(4'hD, 32'h0);
		wrr(4'h1, 32'h2);
		idle(220);
		rdr(4'hD);
		chk("security clear", {31'h0, rv[4]}, 32'h0);
		flow(10, 5, 5, 5);
		wrr(4'h0, 32'h9);
		wrr(4'h6, 32'h3);
		flow(4, 7, 11, 20);
		wrr(4'h0, 32'h8);
		wrr(4'h6, 32'h96);
		// Three hundred pulses pass through the pending buffer without filling it
		flow(4, 9, 311, 5);
		wrr(4'h3, 32'h1);
		wrr(4'h4, 32'h9);
		idle(500);
		chk("relays", relay, 4'h3);
		wrr(4'h7, 32'h61);
		wrr(4'h0, 32'hC);
		idle(500);
		chk("four relays", relay, 4'h7);
		rdr(4'hF);
		chk("audit count", rv, 32'hA);
		wrr(4'h9, 32'h0);
		idle(500);
		chk("analog rate", {20'h0, ana}, 32'h0);
		wrr(4'h9, 32'h1);
		wrr(4'h0, 32'hE);
		for (int i = 0; i < 300 && ana == 12'h0; i++) idle(1);
		chk("analog step", {20'h0, ana}, 32'h4);
		idle(4000);
		chk("analog total", {20'h0, ana}, 32'h9);
		rdr(4'hE);
		chk("analog reg", rv, 32'h9);
		wrr(4'h7, 32'h0);
		rdr(4'h4);
		chk("hidden preset", rv, 32'h0);
		wrr(4'h8, 32'h0001_26F7);
		wrr(4'h8, 32'h0001_26F8);
		idle(2);
		chk("modbus cfg", scfg, 32'h0001_26F7);
		wrr(4'h8, 32'h0000_0064);
		idle(2);
		chk("point id", scfg, 32'h0001_26F7);
		wrr(4'h8, 32'h0000_8601);
		idle(2);
		chk("hw flow ctrl", scfg, 32'h0000_8601);
		wrr(4'h8, 32'h0000_C601);
		idle(2);
		chk("bad flow ctrl", scfg, 32'h0000_8601);
		wrr(4'hA, 32'h0);
		idle(2);
		chk("setup closed", {31'h0, setup}, 32'h0);
		chk("maint closed", {31'h0, maint}, 32'h0);
		finish_test;
	end
endmodule
